// ### rtl/asps_consts.vh
`ifndef ASPS_CONSTS_VH
`define ASPS_CONSTS_VH
// ==========================================
// Clock and filter timing.
`define ASPS_CLK_PERIOD_NS 5
`define ASPS_FILT_SHIFT    8
`define ASPS_TAU0_MS       10'h005
`define ASPS_TAU1_MS       10'h00a
`define ASPS_TAU2_MS       10'h014
`define ASPS_TAU3_MS       10'h028
`define ASPS_TAU4_MS       10'h050
`define ASPS_TAU5_MS       10'h0a0
`define ASPS_TAU6_MS       10'h140
`define ASPS_TAU7_MS       10'h280
`define ASPS_TAU8_MS       10'h3e8
// ==========================================
// Register byte offsets.
`define ASPS_OFS_FILT       8'h00
`define ASPS_OFS_DISP       8'h04
`define ASPS_OFS_VOLT_GF    8'h08
`define ASPS_OFS_VI_GF      8'h0c
`define ASPS_OFS_VOLT_BF    8'h10
`define ASPS_OFS_VOLT_BP    8'h14
`define ASPS_OFS_VOLT_GP    8'h18
`define ASPS_OFS_VI_BF      8'h1c
`define ASPS_OFS_VI_BP      8'h20
`define ASPS_OFS_VI_GP      8'h24
`define ASPS_OFS_SEL        8'h28
`define ASPS_OFS_FREQ       8'h2c
`define ASPS_OFS_LEVEL      8'h30
// ==========================================
// Field positions of the selector register.
`define ASPS_SEL_VOLT_RNG   0
`define ASPS_SEL_VI_RNG_LO  4
`define ASPS_SEL_RESTR      8
`define ASPS_SEL_WP_LO      12
// ==========================================
// Reset values and limits (frequency in 0.01 Hz, points in 0.1 %).
`define ASPS_RST_FILT       4'h1
`define ASPS_MAX_FILT       4'h8
`define ASPS_RST_GF         16'h1388
`define ASPS_RST_BF         16'h0000
`define ASPS_MAX_FREQ       16'h9c40
`define ASPS_RST_VOLT_BP    12'h000
`define ASPS_RST_VOLT_GP    12'h3e8
`define ASPS_RST_VI_BP      12'h0c8
`define ASPS_RST_VI_GP      12'h3e8
`define ASPS_MAX_PT         12'hbb8
`define ASPS_PCT_FULL       12'h3e8
`define ASPS_RST_VOLT_RNG   1'b1
`define ASPS_RST_VI_RNG     2'h0
`define ASPS_MAX_VI_RNG     2'h2
`define ASPS_FS_5V          12'h1f4
`define ASPS_FS_10V         12'h3e8
`define ASPS_FS_20MA        12'h7d0
`endif

// ### rtl/asps_scaler.v
`timescale 1ns/100ps
`include "asps_consts.vh"

module asps_scaler #(
	parameter integer FILT_CYC_PER_MS = (1000000 / `ASPS_CLK_PERIOD_NS) >> `ASPS_FILT_SHIFT
) (
	input  wire        sys_clk_i,
	input  wire        rst_i,
	input  wire        hsel_i,
	input  wire [7:0]  haddr_i,
	input  wire [1:0]  htrans_i,
	input  wire        hwrite_i,
	input  wire [2:0]  hsize_i,
	input  wire [31:0] hwdata_i,
	input  wire        hready_i,
	output wire [31:0] hrdata_o,
	output wire        hreadyout_o,
	output wire        hresp_o,
	input  wire [11:0] volt_sample_i,
	input  wire        volt_sample_valid_i,
	input  wire [11:0] vi_sample_i,
	input  wire        vi_sample_valid_i,
	input  wire        input_select_signal_i,
	output wire [15:0] volt_freq_o,
	output wire [15:0] vi_freq_o,
	output wire [15:0] freq_cmd_o
);

// ==========================================
// Helper functions.
function [9:0] tau_ms;
	input [3:0] sel;
	begin
		case (sel)
			4'h0: tau_ms = `ASPS_TAU0_MS;
			4'h1: tau_ms = `ASPS_TAU1_MS;
			4'h2: tau_ms = `ASPS_TAU2_MS;
			4'h3: tau_ms = `ASPS_TAU3_MS;
			4'h4: tau_ms = `ASPS_TAU4_MS;
			4'h5: tau_ms = `ASPS_TAU5_MS;
			4'h6: tau_ms = `ASPS_TAU6_MS;
			4'h7: tau_ms = `ASPS_TAU7_MS;
			default: tau_ms = `ASPS_TAU8_MS;
		endcase
	end
endfunction

// One lag step: y moves 1/256 of the way to x per tick, so tau is 256 ticks.
function [19:0] filt_step;
	input [19:0] y;
	input [11:0] x;
	reg signed [20:0] d;
	reg signed [20:0] s;
	begin
		d = $signed({1'b0, x, 8'h00}) - $signed({1'b0, y});
		s = $signed({1'b0, y}) + (d >>> `ASPS_FILT_SHIFT);
		filt_step = s[19:0];
	end
endfunction

function [11:0] to_pct;
	input [11:0] code;
	reg [23:0] p;
	begin
		p = code * `ASPS_PCT_FULL + 24'h000800;
		to_pct = p[23:12];
	end
endfunction

function [15:0] map_freq;
	input [11:0] pct;
	input [11:0] bp;
	input [11:0] gp;
	input [15:0] bf;
	input [15:0] gf;
	reg   [15:0] span;
	reg   [11:0] den;
	reg   [11:0] off;
	reg   [27:0] num;
	reg   [27:0] q;
	begin
		span = (gf >= bf) ? gf - bf : bf - gf;
		den = gp - bp;
		off = pct - bp;
		num = span * off + {17'h00000, den[11:1]};
		q = 28'h0000000;
		if (gp <= bp)
			map_freq = (pct < bp) ? bf : gf;
		else if (pct <= bp)
			map_freq = bf;
		else if (pct >= gp)
			map_freq = gf;
		else
		begin
			q = num / {16'h0000, den};
			map_freq = (gf >= bf) ? bf + q[15:0] : bf - q[15:0];
		end
	end
endfunction

function [15:0] to_unit;
	input [11:0] pct;
	input        in_volts;
	input [11:0] fs;
	reg   [23:0] v;
	begin
		v = (pct * fs + 24'h0001f4) / 24'h0003e8;
		to_unit = in_volts ? v[15:0] : {4'h0, pct};
	end
endfunction

// ==========================================
// Settings.
reg [3:0]  filter_setting_r;
reg        display_unit_selector_r;
reg [15:0] volt_in_gain_freq_r;
reg [15:0] vi_in_gain_freq_r;
reg [15:0] volt_in_bias_freq_r;
reg [11:0] volt_in_bias_point_r;
reg [11:0] volt_in_gain_point_r;
reg [15:0] vi_in_bias_freq_r;
reg [11:0] vi_in_bias_point_r;
reg [11:0] vi_in_gain_point_r;
reg        volt_in_range_selector_r;
reg [1:0]  vi_in_range_selector_r;
reg        display_restriction_selector_r;
reg [1:0]  write_protect_selection_r;

// ==========================================
// Bus slave. Writes finish with no wait; reads take one wait state so a read
// right behind a write to the same word already sees the new value.
reg        wr_pend_r;
reg        rd_pend_r;
reg [7:0]  addr_r;
reg [31:0] hrdata_r;
reg        hready_r;
reg [31:0] rd_mux;
wire       take = hsel_i & hready_i & htrans_i[1];
wire [31:0] w = hwdata_i;

reg [19:0] volt_y_r;
reg [19:0] vi_y_r;
reg [15:0] volt_freq_r;
reg [15:0] vi_freq_r;
reg [15:0] cmd_r;
wire [11:0] volt_pct = to_pct(volt_y_r[19:8]);
wire [11:0] vi_pct = to_pct(vi_y_r[19:8]);
wire [11:0] volt_fs = volt_in_range_selector_r ? `ASPS_FS_5V : `ASPS_FS_10V;
wire [11:0] vi_fs = (vi_in_range_selector_r == 2'h1) ? `ASPS_FS_5V :
	(vi_in_range_selector_r == 2'h2) ? `ASPS_FS_10V : `ASPS_FS_20MA;

always @*
begin
	rd_mux = 32'h00000000;
	case (addr_r)
		`ASPS_OFS_FILT:    rd_mux = {28'h0000000, filter_setting_r};
		`ASPS_OFS_DISP:    rd_mux = {31'h00000000, display_unit_selector_r};
		`ASPS_OFS_VOLT_GF: rd_mux = {16'h0000, volt_in_gain_freq_r};
		`ASPS_OFS_VI_GF:   rd_mux = {16'h0000, vi_in_gain_freq_r};
		`ASPS_OFS_VOLT_BF: rd_mux = {16'h0000, volt_in_bias_freq_r};
		`ASPS_OFS_VOLT_BP: rd_mux = {20'h00000, volt_in_bias_point_r};
		`ASPS_OFS_VOLT_GP: rd_mux = {20'h00000, volt_in_gain_point_r};
		`ASPS_OFS_VI_BF:   rd_mux = {16'h0000, vi_in_bias_freq_r};
		`ASPS_OFS_VI_BP:   rd_mux = {20'h00000, vi_in_bias_point_r};
		`ASPS_OFS_VI_GP:   rd_mux = {20'h00000, vi_in_gain_point_r};
		`ASPS_OFS_SEL:     rd_mux = {18'h00000, write_protect_selection_r, 3'h0,
			display_restriction_selector_r, 2'h0, vi_in_range_selector_r, 3'h0, volt_in_range_selector_r};
		`ASPS_OFS_FREQ:    rd_mux = {vi_freq_r, volt_freq_r};
		`ASPS_OFS_LEVEL:   rd_mux = {to_unit(vi_pct, display_unit_selector_r, vi_fs),
			to_unit(volt_pct, display_unit_selector_r, volt_fs)};
		default:           rd_mux = 32'h00000000;
	endcase
end

always @(posedge sys_clk_i or posedge rst_i)
begin
	if (rst_i)
	begin
		wr_pend_r <= 1'b0;
		rd_pend_r <= 1'b0;
		addr_r <= 8'h00;
		hrdata_r <= 32'h00000000;
		hready_r <= 1'b1;
	end
	else
	begin
		if (hready_r)
		begin
			wr_pend_r <= take & hwrite_i;
			rd_pend_r <= take & ~hwrite_i;
			hready_r <= ~(take & ~hwrite_i);
			if (take)
				addr_r <= {haddr_i[7:2], 2'h0};
		end
		else
		begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			hready_r <= 1'b1;
		end
		if (rd_pend_r)
			hrdata_r <= rd_mux;
	end
end

// ==========================================
// Register writes. Out-of-range values are dropped and the old value kept.
// Write protection is stored for software but gates none of these settings.
always @(posedge sys_clk_i or posedge rst_i)
begin
	if (rst_i)
	begin
		filter_setting_r <= `ASPS_RST_FILT;
		display_unit_selector_r <= 1'b0;
		volt_in_gain_freq_r <= `ASPS_RST_GF;
		vi_in_gain_freq_r <= `ASPS_RST_GF;
		volt_in_bias_freq_r <= `ASPS_RST_BF;
		volt_in_bias_point_r <= `ASPS_RST_VOLT_BP;
		volt_in_gain_point_r <= `ASPS_RST_VOLT_GP;
		vi_in_bias_freq_r <= `ASPS_RST_BF;
		vi_in_bias_point_r <= `ASPS_RST_VI_BP;
		vi_in_gain_point_r <= `ASPS_RST_VI_GP;
		volt_in_range_selector_r <= `ASPS_RST_VOLT_RNG;
		vi_in_range_selector_r <= `ASPS_RST_VI_RNG;
		display_restriction_selector_r <= 1'b0;
		write_protect_selection_r <= 2'h0;
	end
	else if (wr_pend_r)
	begin
		case (addr_r)
			`ASPS_OFS_FILT:
				if (!display_restriction_selector_r && w[3:0] <= `ASPS_MAX_FILT && w[31:4] == 28'h0000000)
					filter_setting_r <= w[3:0];
			`ASPS_OFS_DISP:
				if (w[31:1] == 31'h00000000)
					display_unit_selector_r <= w[0];
			`ASPS_OFS_VOLT_GF:
				if (w[31:16] == 16'h0000 && w[15:0] <= `ASPS_MAX_FREQ)
					volt_in_gain_freq_r <= w[15:0];
			`ASPS_OFS_VI_GF:
				if (w[31:16] == 16'h0000 && w[15:0] <= `ASPS_MAX_FREQ)
					vi_in_gain_freq_r <= w[15:0];
			`ASPS_OFS_VOLT_BF:
				if (w[31:16] == 16'h0000 && w[15:0] <= `ASPS_MAX_FREQ)
					volt_in_bias_freq_r <= w[15:0];
			`ASPS_OFS_VOLT_BP:
				if (w[31:12] == 20'h00000 && w[11:0] <= `ASPS_MAX_PT)
					volt_in_bias_point_r <= w[11:0];
			`ASPS_OFS_VOLT_GP:
				if (w[31:12] == 20'h00000 && w[11:0] <= `ASPS_MAX_PT)
					volt_in_gain_point_r <= w[11:0];
			`ASPS_OFS_VI_BF:
				if (w[31:16] == 16'h0000 && w[15:0] <= `ASPS_MAX_FREQ)
					vi_in_bias_freq_r <= w[15:0];
			`ASPS_OFS_VI_BP:
				if (w[31:12] == 20'h00000 && w[11:0] <= `ASPS_MAX_PT)
					vi_in_bias_point_r <= w[11:0];
			`ASPS_OFS_VI_GP:
				if (w[31:12] == 20'h00000 && w[11:0] <= `ASPS_MAX_PT)
					vi_in_gain_point_r <= w[11:0];
			`ASPS_OFS_SEL:
			begin
				volt_in_range_selector_r <= w[`ASPS_SEL_VOLT_RNG];
				if (w[`ASPS_SEL_VI_RNG_LO+1 -: 2] <= `ASPS_MAX_VI_RNG)
					vi_in_range_selector_r <= w[`ASPS_SEL_VI_RNG_LO+1 -: 2];
				display_restriction_selector_r <= w[`ASPS_SEL_RESTR];
				write_protect_selection_r <= w[`ASPS_SEL_WP_LO+1 -: 2];
			end
			default:
				filter_setting_r <= filter_setting_r;
		endcase
	end
end

// ==========================================
// Lag filter. Both channels share one tick; a change of setting applies at once
// to the tick interval in progress, the running average is never reset.
reg  [19:0] tick_cnt_r;
reg  [11:0] volt_x_r;
reg  [11:0] vi_x_r;
wire [31:0] tick_lim = tau_ms(filter_setting_r) * FILT_CYC_PER_MS - 1;
wire        tick = (tick_cnt_r >= tick_lim[19:0]);

always @(posedge sys_clk_i or posedge rst_i)
begin
	if (rst_i)
	begin
		tick_cnt_r <= 20'h00000;
		volt_x_r <= 12'h000;
		vi_x_r <= 12'h000;
		volt_y_r <= 20'h00000;
		vi_y_r <= 20'h00000;
		volt_freq_r <= `ASPS_RST_BF;
		vi_freq_r <= `ASPS_RST_BF;
		cmd_r <= `ASPS_RST_BF;
	end
	else
	begin
		tick_cnt_r <= tick ? 20'h00000 : tick_cnt_r + 20'h00001;
		if (volt_sample_valid_i)
			volt_x_r <= volt_sample_i;
		if (vi_sample_valid_i)
			vi_x_r <= vi_sample_i;
		if (tick)
		begin
			volt_y_r <= filt_step(volt_y_r, volt_x_r);
			vi_y_r <= filt_step(vi_y_r, vi_x_r);
		end
		volt_freq_r <= map_freq(volt_pct, volt_in_bias_point_r, volt_in_gain_point_r,
			volt_in_bias_freq_r, volt_in_gain_freq_r);
		vi_freq_r <= map_freq(vi_pct, vi_in_bias_point_r, vi_in_gain_point_r,
			vi_in_bias_freq_r, vi_in_gain_freq_r);
		cmd_r <= input_select_signal_i ? vi_freq_r : volt_freq_r;
	end
end

assign hrdata_o = hrdata_r;
assign hreadyout_o = hready_r;
assign hresp_o = 1'b0;
assign volt_freq_o = volt_freq_r;
assign vi_freq_o = vi_freq_r;
assign freq_cmd_o = cmd_r;

endmodule

// ### sim/asps_scaler_sva.sv
`timescale 1ns/100ps
// ==========================================
// Port checker.
module asps_scaler_sva (
	input wire        sys_clk_i,
	input wire        rst_i,
	input wire        hsel_i,
	input wire [1:0]  htrans_i,
	input wire        hwrite_i,
	input wire        hready_i,
	input wire [31:0] hrdata_o,
	input wire        hreadyout_o,
	input wire        hresp_o,
	input wire        input_select_signal_i,
	input wire [15:0] volt_freq_o,
	input wire [15:0] vi_freq_o,
	input wire [15:0] freq_cmd_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	wire req = hsel_i & hready_i & htrans_i[1] & hreadyout_o;
	sequence s_one_wait;
		!hreadyout_o ##1 hreadyout_o;
	endsequence
	property p_read_wait;
		req && !hwrite_i |=> s_one_wait;
	endproperty
	property p_write_nowait;
		req && hwrite_i |=> hreadyout_o;
	endproperty
	property p_data_hold;
		!$rose(hreadyout_o) |-> $stable(hrdata_o);
	endproperty
	property p_okay;
		hresp_o == 1'b0;
	endproperty
	property p_cmd_vi;
		$past(input_select_signal_i) |-> freq_cmd_o == $past(vi_freq_o);
	endproperty
	property p_cmd_volt;
		!$past(input_select_signal_i) |-> freq_cmd_o == $past(volt_freq_o);
	endproperty
	property p_volt_max;
		volt_freq_o <= 16'h9c40;
	endproperty
	property p_vi_max;
		vi_freq_o <= 16'h9c40;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read not answered after one wait");
	a_write_nowait: assert property (p_write_nowait) else $error("write stalled");
	a_data_hold: assert property (p_data_hold) else $error("read data moved");
	a_okay: assert property (p_okay) else $error("bad response");
	a_cmd_vi: assert property (p_cmd_vi) else $error("command not from second channel");
	a_cmd_volt: assert property (p_cmd_volt) else $error("command not from first channel");
	a_volt_max: assert property (p_volt_max) else $error("first channel above range");
	a_vi_max: assert property (p_vi_max) else $error("second channel above range");
endmodule
bind asps_scaler asps_scaler_sva u_sva (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(hsel_i),
	.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
	.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .input_select_signal_i(input_select_signal_i),
	.volt_freq_o(volt_freq_o), .vi_freq_o(vi_freq_o), .freq_cmd_o(freq_cmd_o));

// ### sim/asps_src_model.sv
`timescale 1ns/100ps
// ==========================================
// Analog source after conversion.
module asps_src_model (
	input  wire        sys_clk_i,
	input  wire        rst_i,
	input  wire [11:0] level_i,
	input  wire        slow_i,
	output reg  [11:0] sample_o,
	output reg         valid_o
);
	reg [1:0] cnt_r;
	// Between strobes the line carries the inverse, so a design that ignores the strobe is seen.
	always @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_r    <= 2'h0;
			valid_o  <= 1'b0;
			sample_o <= 12'h000;
		end
		else
		begin
			cnt_r    <= cnt_r + 2'h1;
			valid_o  <= !slow_i || cnt_r == 2'h0;
			sample_o <= (!slow_i || cnt_r == 2'h0) ? level_i : ~level_i;
		end
	end
endmodule

// ### sim/analog_setpoint_scaler_tb.sv
`timescale 1ns/100ps
// ==========================================
// Testbench.
module analog_setpoint_scaler_tb;
	reg clk, rst, hsel, hwrite, sel_vi, slow;
	reg [7:0] haddr;
	reg [1:0] htrans;
	reg [31:0] hwdata, rd, rv;
	reg [11:0] lv_volt, lv_vi;
	wire [31:0] hrdata;
	wire hrdy, vv, iv;
	wire [11:0] vs, is;
	wire [15:0] cmd;
	integer n_errors, checks_done, seed, i, n;
	asps_scaler #(.FILT_CYC_PER_MS(1)) u_dut (.sys_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
		.hrdata_o(hrdata), .hreadyout_o(hrdy), .hresp_o(), .volt_sample_i(vs), .volt_sample_valid_i(vv),
		.vi_sample_i(is), .vi_sample_valid_i(iv), .input_select_signal_i(sel_vi), .volt_freq_o(),
		.vi_freq_o(), .freq_cmd_o(cmd));
	asps_src_model u_volt (.sys_clk_i(clk), .rst_i(rst), .level_i(lv_volt), .slow_i(slow), .sample_o(vs), .valid_o(vv));
	asps_src_model u_vi (.sys_clk_i(clk), .rst_i(rst), .level_i(lv_vi), .slow_i(slow), .sample_o(is), .valid_o(iv));
	task report_and_stop;
	begin
		$display("mismatches %0d comparisons %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	end
	endtask
	task chk32(input [8*8:1] nm, input [31:0] exp, input [31:0] got);
	begin
		checks_done = checks_done + 1;
		if (got !== exp)
		begin
			n_errors = n_errors + 1;
			$display("CHECK FAILED %0s expected %h seen %h", nm, exp, got);
		end
	end
	endtask
	task chk_rng(input integer lo, input integer hi, input integer got);
	begin
		checks_done = checks_done + 1;
		if (got < lo || got > hi)
		begin
			n_errors = n_errors + 1;
			$display("CHECK FAILED settle_cycles expected %0d..%0d seen %0d", lo, hi, got);
		end
	end
	endtask
	// Address phase held until hready, then the data phase until hready again.
	task bus(input wr, input [7:0] a, input [31:0] wd);
	begin
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= wr;
		htrans <= 2'h2;
		@(posedge clk);
		while (!hrdy) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (!hrdy) @(posedge clk);
		rd = hrdata;
	end
	endtask
	task rchk(input [7:0] a, input [31:0] exp);
	begin
		bus(1'b0, a, 32'h0);
		chk32("register", exp, rd);
	end
	endtask
	task settle(input [15:0] exp);
	begin
		n = 0;
		while (cmd !== exp && n < 20000)
		begin
			@(posedge clk);
			n = n + 1;
		end
		chk32("freq_cmd", {16'h0, exp}, {16'h0, cmd});
	end
	endtask
	// Line through both calibrated pairs, rounded half up in magnitude, held flat outside the points.
	function [15:0] exp_map(input integer pct, input integer bp, input integer gp, input integer bf, input integer gf);
		integer r;
	begin
		if (pct <= bp)
			r = bf;
		else if (pct >= gp)
			r = gf;
		else if (gf >= bf)
			r = bf + ((gf - bf) * (pct - bp) * 2 + (gp - bp)) / ((gp - bp) * 2);
		else
			r = bf - ((bf - gf) * (pct - bp) * 2 + (gp - bp)) / ((gp - bp) * 2);
		exp_map = r[15:0];
	end
	endfunction
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial
	begin
		repeat (100000) @(posedge clk);
		n_errors = n_errors + 1;
		report_and_stop;
	end
	initial
	begin
		n_errors = 0;
		checks_done = 0;
		seed = 50278;
		rst = 1'b1;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwdata = 32'h0;
		rv = 32'h0;
		sel_vi = 1'b0;
		slow = 1'b0;
		lv_volt = 12'h000;
		lv_vi = 12'h000;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rchk(8'h00, 32'h1);
		rchk(8'h04, 32'h0);
		rchk(8'h08, 32'h1388);
		rchk(8'h0c, 32'h1388);
		rchk(8'h10, 32'h0);
		rchk(8'h14, 32'h0);
		rchk(8'h18, 32'h3e8);
		rchk(8'h1c, 32'h0);
		rchk(8'h20, 32'hc8);
		rchk(8'h24, 32'h3e8);
		rchk(8'h28, 32'h1);
		bus(1'b1, 8'h34, 32'h5);
		rchk(8'h34, 32'h0);
		bus(1'b1, 8'h04, 32'h1);
		rchk(8'h04, 32'h1);
		bus(1'b1, 8'h00, 32'h9);
		rchk(8'h00, 32'h1);
		bus(1'b1, 8'h00, 32'h8);
		rchk(8'h00, 32'h8);
		bus(1'b1, 8'h28, 32'h101);
		bus(1'b1, 8'h00, 32'h0);
		rchk(8'h00, 32'h8);
		bus(1'b1, 8'h28, 32'h3021);
		rchk(8'h28, 32'h3021);
		bus(1'b1, 8'h28, 32'h3031);
		rchk(8'h28, 32'h3021);
		bus(1'b1, 8'h28, 32'h3001);
		bus(1'b1, 8'h00, 32'h3);
		rchk(8'h00, 32'h3);
		for (i = 0; i < 4; i = i + 1)
		begin
			rv = $unsigned($random(seed)) % 40001;
			bus(1'b1, 8'h0c, rv);
			rchk(8'h0c, rv);
		end
		bus(1'b1, 8'h0c, 32'h9c41);
		rchk(8'h0c, rv);
		rchk(8'h20, 32'hc8);
		rchk(8'h24, 32'h3e8);
		// Setting 3 first: the long fall back to the bias is done at setting 0 to keep the run short.
		bus(1'b1, 8'h18, 32'h1f4);
		slow <= 1'b1;
		for (i = 3; i >= 0; i = i - 3)
		begin
			bus(1'b1, 8'h00, i);
			lv_volt <= 12'hfff;
			settle(exp_map(1000, 0, 500, 0, 5000));
			chk_rng(160 * (i ? 40 : 5), 200 * (i ? 40 : 5), n);
			bus(1'b1, 8'h00, 32'h0);
			lv_volt <= 12'h000;
			settle(exp_map(0, 0, 500, 0, 5000));
		end
		slow <= 1'b0;
		bus(1'b1, 8'h18, 32'h3e8);
		bus(1'b1, 8'h08, 32'h9c40);
		lv_volt <= 12'h800;
		settle(exp_map(500, 0, 1000, 0, 40000));
		rchk(8'h30, 32'h000000fa);
		rchk(8'h2c, 32'h00004e20);
		bus(1'b1, 8'h1c, 32'h9c40);
		bus(1'b1, 8'h0c, 32'h0);
		bus(1'b1, 8'h24, 32'h384);
		sel_vi <= 1'b1;
		settle(exp_map(0, 200, 900, 40000, 0));
		lv_vi <= 12'hfff;
		settle(exp_map(1000, 200, 900, 40000, 0));
		lv_vi <= 12'h8cd;
		settle(exp_map(550, 200, 900, 40000, 0));
		rchk(8'h30, 32'h044c00fa);
		rchk(8'h2c, 32'h4e204e20);
		bus(1'b1, 8'h04, 32'h0);
		rchk(8'h30, 32'h022601f4);
		report_and_stop;
	end
endmodule
